// ==== logic/ivp_pkg.sv ====
// ivp_pkg: constants for the interrupt vectoring and priority block.
// assumes a 24-bit core data bus and 2-bit level fields per source group.
package ivp_pkg;

    localparam int N_SRC   = 36;
    localparam int N_EXC   = 6;
    localparam int IDX_W   = 6;
    localparam int N_LEVEL = 3;

    // register addresses in peripheral data space
    localparam logic [23:0] ADDR_CORE_LEVEL = 24'h0FFFFF;
    localparam logic [23:0] ADDR_PERI_LEVEL = 24'h0FFFFE;

    // implemented bits; the rest read as zero
    localparam logic [23:0] CORE_LEVEL_MASK = 24'h0000FF;
    localparam logic [23:0] PERI_LEVEL_MASK = 24'h3FFFFF;
    localparam logic [23:0] CORE_LEVEL_RST  = 24'h000000;
    localparam logic [23:0] PERI_LEVEL_RST  = 24'h000000;

    // level field: 0 disables the source, 1..3 mean level 0..2
    localparam int          LVL_FIELD_W = 2;
    localparam logic [1:0]  LVL_CODE_OFF = 2'h0;
    localparam logic [1:0]  LEVEL_NMI    = 2'h3;
    localparam int          N_CORE_GRP   = 4;

    // level-3 slots are two apart from offset 0; 6 and 7 stay reserved
    localparam logic [6:0]  SLOT_RSV_A = 7'h06;
    localparam logic [6:0]  SLOT_RSV_B = 7'h07;

    typedef logic [7:0] ivp_off_t;
    typedef logic [3:0] ivp_grp_t;

    // maskable sources in fixed priority order, highest first
    localparam ivp_off_t SRC_OFF [N_SRC] = '{
        8'h10, 8'h12, 8'h14, 8'h16,
        8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20, 8'h22,
        8'h34, 8'h32, 8'h30, 8'h36, 8'h3C, 8'h3E, 8'h3A, 8'h38,
        8'h4C, 8'h4A, 8'h42, 8'h48, 8'h40, 8'h44,
        8'h64, 8'h60, 8'h62,
        8'h28, 8'h2A, 8'h2E,
        8'h56, 8'h54, 8'h5A, 8'h58, 8'h5E, 8'h5C
    };

    // group 0..3 ext lines, 4..9 dma, 10 audio serial, 11 serial host,
    // 12 parallel host, 13 audio transmitter, 14 timer unit
    localparam ivp_grp_t SRC_GRP [N_SRC] = '{
        4'h0, 4'h1, 4'h2, 4'h3,
        4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
        4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA,
        4'hB, 4'hB, 4'hB, 4'hB, 4'hB, 4'hB,
        4'hC, 4'hC, 4'hC,
        4'hD, 4'hD, 4'hD,
        4'hE, 4'hE, 4'hE, 4'hE, 4'hE, 4'hE
    };

endpackage

// ==== logic/ivp_first_set.sv ====
// ivp_first_set: finds the lowest-numbered set bit of a request vector.
// purely combinational; index 0 is the highest priority.
`timescale 1ns/100ps
module ivp_first_set #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] req_i,
    output logic              found_o,
    output logic [5:0]        index_o
);

    always_comb
    begin
        found_o = 1'b0;
        index_o = 6'h00;
        // scan downward so the lowest set index is left last
        for (int i = W - 1; i >= 0; i--)
        begin
            if (req_i[i])
            begin
                found_o = 1'b1;
                index_o = 6'(i);
            end
        end
    end

endmodule

// ==== logic/ivp_top.sv ====
// ivp_top: interrupt vectoring and fixed-priority arbitration.
// assumes requests are levels synchronous to clk_i, held until served.
`timescale 1ns/100ps

// How it works
// - vector address is vector base plus per-source offset, slots two apart.
// - six exception sources are level 3, never masked, offsets 00 to 0A.
// - offsets 0C and 0E are reserved and never produced.
// - each external and peripheral source gets a level 0 to 2, maskable.
// - same-level maskable requests resolve in one fixed order.
// - audio serial port requests vector to offsets 30 through 3E.
// - serial host port requests vector to 40,42,44,48,4A,4C.
// - parallel host port requests vector to 60, 62 and 64.
// - audio transmitter vectors to 28, 2A, 2E; 2C stays reserved.
// - two level assignment registers at the top of peripheral space.
module ivp_top (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [23:0] addr_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [23:0] wdata_i,
    output logic      [23:0] rdata_o,
    input  wire logic [23:0] vector_base_i,
    input  wire logic [1:0]  core_mask_i,
    input  wire logic [5:0]  exc_req_i,
    input  wire logic [35:0] src_req_i,
    output logic             irq_valid_o,
    output logic      [1:0]  priority_level_o,
    output logic      [6:0]  irq_slot_o,
    output logic      [23:0] irq_vector_o
);

    logic [23:0] core_level_assign;
    logic [23:0] peripheral_level_assign;

    // level code of a group from the two assignment registers
    function automatic logic [1:0] field_code(
        input logic [23:0]      core_r,
        input logic [23:0]      peri_r,
        input ivp_pkg::ivp_grp_t grp
    );
        logic [4:0] pos;
        pos = 5'h00;
        if (int'(grp) < ivp_pkg::N_CORE_GRP)
        begin
            pos = 5'(int'(grp) * ivp_pkg::LVL_FIELD_W);
            field_code = core_r[pos +: 2];
        end
        else
        begin
            pos = 5'((int'(grp) - ivp_pkg::N_CORE_GRP)
                     * ivp_pkg::LVL_FIELD_W);
            field_code = peri_r[pos +: 2];
        end
    endfunction

    wire hit_core = (addr_i == ivp_pkg::ADDR_CORE_LEVEL);
    wire hit_peri = (addr_i == ivp_pkg::ADDR_PERI_LEVEL);

    logic [23:0] next_rdata;
    always_comb
    begin
        if (rd_i && hit_core)
            next_rdata = core_level_assign;
        else if (rd_i && hit_peri)
            next_rdata = peripheral_level_assign;
        else
            next_rdata = 24'h000000;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            core_level_assign       <= ivp_pkg::CORE_LEVEL_RST;
            peripheral_level_assign <= ivp_pkg::PERI_LEVEL_RST;
            rdata_o                 <= 24'h000000;
        end
        else
        begin
            if (wr_i && hit_core)
                core_level_assign <= wdata_i & ivp_pkg::CORE_LEVEL_MASK;
            if (wr_i && hit_peri)
                peripheral_level_assign <=
                    wdata_i & ivp_pkg::PERI_LEVEL_MASK;
            rdata_o <= next_rdata;
        end
    end

    // per-level eligible request vectors, already filtered by the mask
    logic [ivp_pkg::N_SRC-1:0] elig [ivp_pkg::N_LEVEL];
    logic [1:0]                src_code [ivp_pkg::N_SRC];

    genvar gs;
    genvar gl;
    generate
        for (gs = 0; gs < ivp_pkg::N_SRC; gs++)
        begin : g_src
            assign src_code[gs] = field_code(core_level_assign,
                peripheral_level_assign, ivp_pkg::SRC_GRP[gs]);
            for (gl = 0; gl < ivp_pkg::N_LEVEL; gl++)
            begin : g_lvl
                // mask value m blocks levels below m; 3 blocks all
                assign elig[gl][gs] = src_req_i[gs]
                    && (src_code[gs] == 2'(gl + 1))
                    && (2'(gl) >= core_mask_i);
            end
        end
    endgenerate

    logic                found_lvl [ivp_pkg::N_LEVEL];
    logic [5:0]          index_lvl [ivp_pkg::N_LEVEL];
    logic                found_exc;
    logic [5:0]          index_exc;

    generate
        for (gl = 0; gl < ivp_pkg::N_LEVEL; gl++)
        begin : g_pick
            ivp_first_set #(.W(ivp_pkg::N_SRC)) u_pick (
                .req_i   (elig[gl]),
                .found_o (found_lvl[gl]),
                .index_o (index_lvl[gl])
            );
        end
    endgenerate

    ivp_first_set #(.W(ivp_pkg::N_EXC)) u_exc (
        .req_i   (exc_req_i),
        .found_o (found_exc),
        .index_o (index_exc)
    );

    logic       next_valid;
    logic [1:0] next_level;
    logic [6:0] next_slot;
    always_comb
    begin
        next_valid = 1'b1;
        next_level = ivp_pkg::LEVEL_NMI;
        next_slot  = 7'h00;
        // exceptions first, then maskable levels high to low
        if (found_exc)
            next_slot = {1'b0, index_exc};
        else if (found_lvl[2])
        begin
            next_level = 2'h2;
            next_slot  = ivp_pkg::SRC_OFF[index_lvl[2]][7:1];
        end
        else if (found_lvl[1])
        begin
            next_level = 2'h1;
            next_slot  = ivp_pkg::SRC_OFF[index_lvl[1]][7:1];
        end
        else if (found_lvl[0])
        begin
            next_level = 2'h0;
            next_slot  = ivp_pkg::SRC_OFF[index_lvl[0]][7:1];
        end
        else
        begin
            next_valid = 1'b0;
            next_level = 2'h0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            irq_valid_o      <= 1'b0;
            priority_level_o <= 2'h0;
            irq_slot_o       <= 7'h00;
            irq_vector_o     <= 24'h000000;
        end
        else
        begin
            irq_valid_o      <= next_valid;
            priority_level_o <= next_level;
            irq_slot_o       <= next_slot;
            // offset is the slot doubled
            irq_vector_o <= vector_base_i + {16'h0000, next_slot, 1'b0};
        end
    end

    // helpers for checks
    wire only_src0 = (src_req_i == 36'h000000001) && (exc_req_i == 6'h00);
    wire only_dma0 = (src_req_i == 36'h000000010) && (exc_req_i == 6'h00);
    wire only_hcmd = (src_req_i == 36'h001000000) && (exc_req_i == 6'h00);
    wire only_as   = (src_req_i == 36'h00003FC00) && (exc_req_i == 6'h00);

    property p_exc_wins;
        @(posedge clk_i) disable iff (!rst_b_i)
        (exc_req_i != 6'h00) |=> irq_valid_o
            && (priority_level_o == 2'h3) && (irq_slot_o < 7'h06);
    endproperty
    a_exc_wins: assert property (p_exc_wins)
        else $error("exception did not win at level 3");

    property p_no_rsv;
        @(posedge clk_i) disable iff (!rst_b_i)
        irq_valid_o |-> (irq_slot_o != ivp_pkg::SLOT_RSV_A)
            && (irq_slot_o != ivp_pkg::SLOT_RSV_B);
    endproperty
    a_no_rsv: assert property (p_no_rsv)
        else $error("reserved level 3 slot produced");

    property p_vec_sum;
        @(posedge clk_i) disable iff (!rst_b_i)
        ##1 irq_valid_o |-> irq_vector_o ==
            $past(vector_base_i) + {16'h0000, irq_slot_o, 1'b0};
    endproperty
    a_vec_sum: assert property (p_vec_sum)
        else $error("vector is not base plus offset");

    property p_mask_ok;
        @(posedge clk_i) disable iff (!rst_b_i)
        ##1 (irq_valid_o && priority_level_o != 2'h3)
            |-> priority_level_o >= $past(core_mask_i);
    endproperty
    a_mask_ok: assert property (p_mask_ok)
        else $error("masked level was serviced");

    property p_src0_first;
        @(posedge clk_i) disable iff (!rst_b_i)
        (exc_req_i == 6'h00 && src_req_i[0] && src_code[0] == 2'h3
            && core_mask_i != 2'h3)
            |=> irq_valid_o && irq_slot_o == 7'h08
                && priority_level_o == 2'h2;
    endproperty
    a_src0_first: assert property (p_src0_first)
        else $error("line a at top level did not win");

    property p_disabled;
        @(posedge clk_i) disable iff (!rst_b_i)
        (only_src0 && src_code[0] == ivp_pkg::LVL_CODE_OFF) |=> !irq_valid_o;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled source was forwarded");

    property p_dma0;
        @(posedge clk_i) disable iff (!rst_b_i)
        (only_dma0 && src_code[4] == 2'h3 && core_mask_i != 2'h3)
            |=> irq_slot_o == 7'h0C;
    endproperty
    a_dma0: assert property (p_dma0)
        else $error("dma channel 0 slot wrong");

    property p_hcmd;
        @(posedge clk_i) disable iff (!rst_b_i)
        (only_hcmd && src_code[24] == 2'h3 && core_mask_i != 2'h3)
            |=> irq_slot_o == 7'h32;
    endproperty
    a_hcmd: assert property (p_hcmd)
        else $error("host command slot wrong");

    property p_reg_rd;
        @(posedge clk_i) disable iff (!rst_b_i)
        (wr_i && hit_core) ##1 (rd_i && hit_core && !wr_i)
            |=> rdata_o == ($past(wdata_i, 2) & ivp_pkg::CORE_LEVEL_MASK);
    endproperty
    a_reg_rd: assert property (p_reg_rd)
        else $error("core level register readback wrong");

    property p_peri_rd;
        @(posedge clk_i) disable iff (!rst_b_i)
        (wr_i && hit_peri) ##1 (rd_i && hit_peri && !wr_i)
            |=> rdata_o == ($past(wdata_i, 2) & ivp_pkg::PERI_LEVEL_MASK);
    endproperty
    a_peri_rd: assert property (p_peri_rd)
        else $error("peripheral level register readback wrong");

    // read data stands one cycle only, so a stale word cannot be reread
    property p_rd_idle;
        @(posedge clk_i) disable iff (!rst_b_i)
        !rd_i |=> rdata_o == 24'h000000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data shown without a read");

    property p_mask_all;
        @(posedge clk_i) disable iff (!rst_b_i)
        (core_mask_i == 2'h3 && exc_req_i == 6'h00) |=> !irq_valid_o;
    endproperty
    a_mask_all: assert property (p_mask_all)
        else $error("maskable request passed a full mask");

    property p_lvl_order;
        @(posedge clk_i) disable iff (!rst_b_i)
        (!found_exc && !found_lvl[2] && found_lvl[1] && found_lvl[0])
            |=> irq_valid_o && priority_level_o == 2'h1;
    endproperty
    a_lvl_order: assert property (p_lvl_order)
        else $error("lower level won over a higher one");

    property p_as_order;
        @(posedge clk_i) disable iff (!rst_b_i)
        (only_as && src_code[10] == 2'h3 && core_mask_i != 2'h3)
            |=> irq_slot_o == 7'h1A;
    endproperty
    a_as_order: assert property (p_as_order)
        else $error("audio serial receive exception did not win");

endmodule

// ==== testbench/ivp_req_model.sv ====
// ivp_req_model: requesters standing behind the arbiter.
// assumes commands change off the rising edge; requests are held levels.
`timescale 1ns/100ps
module ivp_req_model (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [5:0]  exc_set_i,
    input  wire logic [35:0] src_set_i,
    output logic      [5:0]  exc_req_o,
    output logic      [35:0] src_req_o
);
    // no ack exists, so a request stays up until its owner drops it
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            exc_req_o <= 6'h00;
            src_req_o <= 36'h0;
        end
        else
        begin
            exc_req_o <= exc_set_i;
            src_req_o <= src_set_i;
        end
    end
endmodule

// ==== testbench/tb.sv ====
// tb: reset and register checks, then table-driven vector and arbitration cases.
// assumes ivp_top and the request model; inputs move at falling edges.
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module tb;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [23:0] addr_i = 24'h000000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [23:0] wdata_i = 24'h000000;
    logic [23:0] vector_base_i = 24'h0ABC00;
    logic [1:0]  core_mask_i = 2'h0;
    logic [5:0]  exc_set = 6'h00;
    logic [35:0] src_set = 36'h0;
    logic [5:0]  exc_req_i;
    logic [35:0] src_req_i;
    logic [23:0] rdata_o;
    logic        irq_valid_o;
    logic [1:0]  priority_level_o;
    logic [6:0]  irq_slot_o;
    logic [23:0] irq_vector_o;
    int          err_count = 0;
    int          cmp_count = 0;
    // row i: exceptions first, then maskable sources by priority index
    logic [7:0]  off_tab [42] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A,
        8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20,
        8'h22, 8'h34, 8'h32, 8'h30, 8'h36, 8'h3C, 8'h3E, 8'h3A, 8'h38,
        8'h4C, 8'h4A, 8'h42, 8'h48, 8'h40, 8'h44, 8'h64, 8'h60, 8'h62,
        8'h28, 8'h2A, 8'h2E, 8'h56, 8'h54, 8'h5A, 8'h58, 8'h5E, 8'h5C};

    always #5 clk_i = ~clk_i;

    ivp_req_model u_req (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .exc_set_i(exc_set), .src_set_i(src_set),
        .exc_req_o(exc_req_i), .src_req_o(src_req_i));

    ivp_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .vector_base_i(vector_base_i), .core_mask_i(core_mask_i),
        .exc_req_i(exc_req_i), .src_req_i(src_req_i),
        .irq_valid_o(irq_valid_o), .priority_level_o(priority_level_o),
        .irq_slot_o(irq_slot_o), .irq_vector_o(irq_vector_o));

    task automatic wr(input logic [23:0] a, input logic [23:0] d);
        @(negedge clk_i);
        addr_i = a;
        wdata_i = d;
        wr_i = 1'b1;
        @(negedge clk_i);
        wr_i = 1'b0;
    endtask

    // called at a falling edge, so a read may follow a write directly
    task automatic rd(input logic [23:0] a, input logic [23:0] exp);
        addr_i = a;
        rd_i = 1'b1;
        @(negedge clk_i);
        rd_i = 1'b0;
        `CHK(rdata_o, exp)
        @(negedge clk_i);
        `CHK(rdata_o, 24'h000000)
    endtask

    // one edge through the model, one through the arbiter
    task automatic arb(input logic [5:0] e, input logic [35:0] s,
        input logic v, input logic [1:0] l, input logic [7:0] off);
        @(negedge clk_i);
        exc_set = e;
        src_set = s;
        repeat (2) @(negedge clk_i);
        `CHK(irq_valid_o, v)
        if (v)
        begin
            `CHK(priority_level_o, l)
            `CHK(irq_slot_o, off[7:1])
            `CHK(irq_vector_o, vector_base_i + {16'h0000, off})
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        #50000;
        err_count++;
        complete_run();
    end

    initial
    begin
        repeat (8) @(negedge clk_i);
        `CHK(irq_valid_o, 1'b0)
        `CHK(irq_vector_o, 24'h000000)
        rst_b_i = 1'b1;
        // cleared level fields leave line a disabled
        arb(6'h00, 36'h000000001, 1'b0, 2'h0, 8'h00);
        rd(24'h0FFFFF, 24'h000000);
        rd(24'h0FFFFE, 24'h000000);
        $display("test reset done");
        wr(24'h0FFFFF, 24'hFFFFFF);
        rd(24'h0FFFFF, 24'h0000FF);
        wr(24'h0FFFFE, 24'hFFFFFF);
        rd(24'h0FFFFE, 24'h3FFFFF);
        wr(24'h0FFFFD, 24'h123456);
        rd(24'h0FFFFD, 24'h000000);
        $display("test registers done");
        for (int i = 0; i < 42; i++)
            if (i < 6)
                arb(6'h01 << i, 36'h0, 1'b1, 2'h3, off_tab[i]);
            else
                arb(6'h00, 36'h1 << (i - 6), 1'b1, 2'h2, off_tab[i]);
        $display("test vector table done");
        arb(6'h00, 36'h0003FC00, 1'b1, 2'h2, 8'h34);
        arb(6'h00, 36'hFC0000000, 1'b1, 2'h2, 8'h56);
        arb(6'h00, 36'h221000000, 1'b1, 2'h2, 8'h64);
        vector_base_i = 24'h123400;
        arb(6'h00, 36'h000003000, 1'b1, 2'h2, 8'h30);
        arb(6'h00, 36'h000C00000, 1'b1, 2'h2, 8'h40);
        arb(6'h00, 36'h030000000, 1'b1, 2'h2, 8'h2A);
        arb(6'h3C, 36'hFFFFFFFFF, 1'b1, 2'h3, 8'h04);
        core_mask_i = 2'h3;
        arb(6'h00, 36'hFFFFFFFFF, 1'b0, 2'h0, 8'h00);
        core_mask_i = 2'h0;
        wr(24'h0FFFFF, 24'h000001);
        wr(24'h0FFFFE, 24'h000002);
        // ext line a at level 0, dma0 at level 1
        arb(6'h00, 36'h000000011, 1'b1, 2'h1, 8'h18);
        arb(6'h00, 36'h000000400, 1'b0, 2'h0, 8'h00);
        core_mask_i = 2'h1;
        arb(6'h00, 36'h000000001, 1'b0, 2'h0, 8'h00);
        core_mask_i = 2'h2;
        arb(6'h00, 36'h000000011, 1'b0, 2'h0, 8'h00);
        arb(6'h20, 36'h000000011, 1'b1, 2'h3, 8'h0A);
        arb(6'h00, 36'h0, 1'b0, 2'h0, 8'h00);
        $display("test priority done");
        complete_run();
    end
endmodule
